//--- hw/asc_regs.svh
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ASC_MODE_OFF     8'h00
`define ASC_CHSEL_OFF    8'h04
`define ASC_RESULT_OFF   8'h08
`define ASC_RESULT_H_OFF 8'h0C
`define ASC_IRQ_ST_OFF   8'h10
`define ASC_IRQ_MSK_OFF  8'h14
`define ASC_STATUS_OFF   8'h18
`define ASC_CHRES_OFF    8'h1C
// ---------------------------------------------------------------
// mode register fields
// ---------------------------------------------------------------
`define ASC_MODE_EN_BIT  0
`define ASC_MODE_PWR_BIT 1
`define ASC_MODE_SLO_BIT 2
`define ASC_MODE_SHI_BIT 3
`define ASC_MODE_FR_LSB  4
`define ASC_MODE_RST     7'h00
// ---------------------------------------------------------------
// interrupt status bits
// ---------------------------------------------------------------
`define ASC_IRQ_END_BIT  0
`define ASC_IRQ_SUS_BIT  1
`define ASC_IRQ_RST      2'h0
// ---------------------------------------------------------------
// timing, delays in ns, clock period in ns; _CYC, sampling bases and sar step in clock cycles
// ---------------------------------------------------------------
`define ASC_CLK_NS       25
`define ASC_SETTLE_HS_NS 1000
`define ASC_SETTLE_NM_NS 14000
`define ASC_START_DLY_NS 100
`define ASC_SETTLE_HS_CYC ((`ASC_SETTLE_HS_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_SETTLE_NM_CYC ((`ASC_SETTLE_NM_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_START_DLY_CYC ((`ASC_START_DLY_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_SAMP_BASE_HS 8
`define ASC_SAMP_BASE_NM 32
`define ASC_SAR_STEP     4
`endif

//--- hw/asc_pkg.sv
package asc_pkg;
  // ---------------------------------------------------------------
  // sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_DELAY  = 5'b00010,
    ST_SAMPLE = 5'b00100,
    ST_CONV   = 5'b01000,
    ST_DONE   = 5'b10000
  } asc_state_t;
  typedef logic [9:0] asc_code_t;  // converter code width
endpackage

//--- hw/asc_res_mem.sv
`timescale 1ns/1ps
// per-channel store of the last result, registered read data
module asc_res_mem
  import asc_pkg::*;
(
  input  wire logic      sys_clk_i,  // system clock
  input  wire logic      wr_en_i,    // write strobe
  input  wire logic [2:0] wr_addr_i, // written channel
  input  wire asc_code_t wr_data_i,  // written code
  input  wire logic [2:0] rd_addr_i, // read channel
  output asc_code_t      rd_data_o   // registered read data
);
  asc_code_t mem_q [8];  // one word per channel
  // write port
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end
  // read port, one cycle latency
  always_ff @(posedge sys_clk_i) begin
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule // asc_res_mem

//--- hw/asc_ctrl.sv
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "asc_regs.svh"
// Function
// RQ1: channel-select write keeps conversion-end flag
// RQ2: old-channel end may leave flag set
// RQ3: software clears flag before restarting conversion
// RQ4: software waits settle time before enabling
// RQ5: enable without power marks first result suspect
// RQ6: software discards suspect first result
// RQ7: mode or channel write invalidates result; a same-cycle conversion end leaves it valid
// RQ8: software reads result before mode/channel writes
// RQ9: no result access while main clock stopped
// RQ10: sampling length follows mode register
// RQ11: sampling starts after a start delay
// RQ12: writes take effect after the wait period
// RQ13: no mode writes mid-conversion in normal
// RQ14: conversion end sets flag, pulses interrupt
module asc_ctrl
  import asc_pkg::*;
(
  input  wire logic        sys_clk_i,      // system clock, 40 MHz
  input  wire logic        reset_i,        // async reset, active high
  input  wire logic        psel_i,         // apb select
  input  wire logic        penable_i,      // apb enable
  input  wire logic        pwrite_i,       // apb direction
  input  wire logic [7:0]  paddr_i,        // apb byte address
  input  wire logic [31:0] pwdata_i,       // apb write data
  output logic      [31:0] prdata_o,       // apb read data
  output logic             pready_o,       // apb ready
  output logic             pslverr_o,      // apb error, unmapped
  input  wire logic        comp_i,         // comparator, async
  output logic             sample_o,       // sample and hold gate
  output logic      [2:0]  channel_o,      // analog mux select
  output logic      [9:0]  dac_code_o,     // trial code to dac
  output logic             power_on_o,     // converter power
  output logic             conv_end_irq_o, // one-cycle end pulse
  output logic             irq_o           // masked level interrupt
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // sampling length in cycles from speed and fine select
  function automatic logic [7:0] asc_samp_cycles(input logic [1:0] spd,
                                                 input logic [1:0] fr);
    logic [7:0] base;
    base = (spd == 2'h0) ? 8'(`ASC_SAMP_BASE_NM) : 8'(`ASC_SAMP_BASE_HS);
    return 8'(base * ({6'h00, fr} + 8'h01));
  endfunction
  // address match for one register
  function automatic logic asc_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic       ready_q;        // wait state done
  logic       wr_en;          // write completes this cycle
  logic [6:0] mode_q;         // adc_mode_reg
  logic [2:0] chsel_q;        // channel_select_reg
  asc_code_t  result_q;       // conv_result_reg
  logic       result_vld_q;   // result defined
  logic [1:0] irq_st_q;       // adc_irq_ctrl status, w1c
  logic [1:0] irq_msk_q;      // interrupt mask
  logic [9:0] settle_q;       // power settle countdown
  logic       suspect_q;      // next result may be inaccurate
  asc_state_t state_q;        // sequencer state
  logic [7:0] timer_q;        // delay, sample, step timer
  logic [3:0] bit_q;          // sar bit index
  asc_code_t  trial_q;        // sar trial code
  logic       comp_m_q;       // comparator sync stage 1
  logic       comp_s_q;       // comparator sync stage 2
  asc_code_t  mem_rd;         // channel store read data
  logic       done;           // conversion finished this cycle
  logic       en_bit;         // conv_enable_bit
  logic       pwr_bit;        // conv_power_on_bit
  logic [1:0] spd;            // speed_select_hi, speed_select_lo
  logic       wr_mode;        // mode register written
  logic       wr_chsel;       // channel register written
  logic       en_rise;        // enable written from 0 to 1
  logic [31:0] rd_mux;        // read data select

  assign en_bit  = mode_q[`ASC_MODE_EN_BIT];
  assign pwr_bit = mode_q[`ASC_MODE_PWR_BIT];
  assign spd     = {mode_q[`ASC_MODE_SHI_BIT], mode_q[`ASC_MODE_SLO_BIT]};
  assign done    = (state_q == ST_DONE);

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // one wait state; every register write lands at the completing edge
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= psel_i & penable_i & ~ready_q;
    end
  end
  assign pready_o = ready_q;
  assign wr_en    = psel_i & penable_i & pwrite_i & ready_q;  // RQ12
  assign wr_mode  = wr_en & asc_hit(paddr_i, `ASC_MODE_OFF);
  assign wr_chsel = wr_en & asc_hit(paddr_i, `ASC_CHSEL_OFF);
  assign en_rise  = wr_mode & pwdata_i[`ASC_MODE_EN_BIT] & ~en_bit;

  // read data select
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      `ASC_MODE_OFF:     rd_mux = {25'h0, mode_q};
      `ASC_CHSEL_OFF:    rd_mux = {29'h0, chsel_q};
      `ASC_RESULT_OFF:   rd_mux = {22'h0, result_q};
      `ASC_RESULT_H_OFF: rd_mux = {24'h0, result_q[9:2]};
      `ASC_IRQ_ST_OFF:   rd_mux = {30'h0, irq_st_q};
      `ASC_IRQ_MSK_OFF:  rd_mux = {30'h0, irq_msk_q};
      `ASC_STATUS_OFF:   rd_mux = {20'h0, state_q, 4'h0, (settle_q == 10'h000),
                                   suspect_q, result_vld_q};
      `ASC_CHRES_OFF:    rd_mux = {22'h0, mem_rd};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // read data and error captured in the wait cycle
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i & penable_i & ~ready_q) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pslverr_o <= (paddr_i[1:0] != 2'h0) | (paddr_i > `ASC_CHRES_OFF);
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // mode, channel and mask written only at completion
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q    <= `ASC_MODE_RST;
      chsel_q   <= 3'h0;
      irq_msk_q <= `ASC_IRQ_RST;
    end else begin
      if (wr_mode) begin
        mode_q <= pwdata_i[6:0];  // RQ12
      end
      if (wr_chsel) begin
        chsel_q <= pwdata_i[2:0];  // RQ12
      end
      if (wr_en & asc_hit(paddr_i, `ASC_IRQ_MSK_OFF)) begin
        irq_msk_q <= pwdata_i[1:0];
      end
    end
  end
  assign power_on_o = pwr_bit;
  assign channel_o  = chsel_q;

  // ---------------------------------------------------------------
  // power settle tracking
  // ---------------------------------------------------------------
  // countdown restarts when power is switched on
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      settle_q <= 10'h000;
    end else if (wr_mode & pwdata_i[`ASC_MODE_PWR_BIT] & ~pwr_bit) begin
      settle_q <= (pwdata_i[`ASC_MODE_SHI_BIT:`ASC_MODE_SLO_BIT] == 2'h0)
                  ? 10'(`ASC_SETTLE_NM_CYC) : 10'(`ASC_SETTLE_HS_CYC);
    end else if (~pwr_bit) begin
      settle_q <= 10'h000;
    end else if (settle_q != 10'h000) begin
      settle_q <= settle_q - 10'h001;
    end
  end

  // first result after an early or unpowered enable is marked
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      suspect_q <= 1'b0;
    end else if (en_rise) begin
      suspect_q <= ~pwdata_i[`ASC_MODE_PWR_BIT] | ~pwr_bit |
                   (settle_q != 10'h000);  // RQ5
    end else if (done) begin
      suspect_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // comparator synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      comp_m_q <= 1'b0;
      comp_s_q <= 1'b0;
    end else begin
      comp_m_q <= comp_i;
      comp_s_q <= comp_m_q;
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  // idle, start delay, sample, sar steps, done, then resample
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      timer_q <= 8'h00;
      bit_q   <= 4'h0;
      trial_q <= 10'h000;
    end else if (~en_bit) begin
      state_q <= ST_IDLE;  // stop at once when disabled
      timer_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_DELAY;  // RQ11
          timer_q <= 8'(`ASC_START_DLY_CYC - 1);
        end
        ST_DELAY: begin
          if (timer_q == 8'h00) begin
            state_q <= ST_SAMPLE;
            timer_q <= asc_samp_cycles(spd, mode_q[5:4]) - 8'h01;  // RQ10
          end else begin
            timer_q <= timer_q - 8'h01;
          end
        end
        ST_SAMPLE: begin
          if (timer_q == 8'h00) begin
            state_q <= ST_CONV;
            trial_q <= 10'h200;
            bit_q   <= 4'h9;
            timer_q <= 8'(`ASC_SAR_STEP - 1);
          end else begin
            timer_q <= timer_q - 8'h01;
          end
        end
        ST_CONV: begin
          if (timer_q != 8'h00) begin
            timer_q <= timer_q - 8'h01;
          end else begin
            // keep the trial bit when input is at or above it
            trial_q[bit_q] <= comp_s_q;
            timer_q        <= 8'(`ASC_SAR_STEP - 1);
            if (bit_q == 4'h0) begin
              state_q <= ST_DONE;
            end else begin
              trial_q[bit_q - 4'h1] <= 1'b1;
              bit_q                 <= bit_q - 4'h1;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_SAMPLE;  // continuous conversion
          timer_q <= asc_samp_cycles(spd, mode_q[5:4]) - 8'h01;  // RQ10
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
  assign sample_o   = (state_q == ST_SAMPLE);
  assign dac_code_o = trial_q;

  // ---------------------------------------------------------------
  // result register
  // ---------------------------------------------------------------
  // mode or channel write leaves the result undefined unless a conversion ends in the same cycle
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      result_q     <= 10'h000;
      result_vld_q <= 1'b0;
    end else if (done) begin
      result_q     <= trial_q;  // RQ14
      result_vld_q <= 1'b1;
    end else if (wr_mode | wr_chsel) begin
      result_vld_q <= 1'b0;  // RQ7
    end
  end

  asc_res_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (done),
    .wr_addr_i (chsel_q),
    .wr_data_i (trial_q),
    .rd_addr_i (chsel_q),
    .rd_data_o (mem_rd)
  );

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  // sticky flags, write one to clear, set wins; channel write ignored
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_st_q <= `ASC_IRQ_RST;
    end else begin
      if (wr_en & asc_hit(paddr_i, `ASC_IRQ_ST_OFF)) begin
        irq_st_q <= irq_st_q & ~pwdata_i[1:0];  // RQ1
      end
      if (done) begin
        irq_st_q[`ASC_IRQ_END_BIT] <= 1'b1;  // RQ14 RQ2
        if (suspect_q) begin
          irq_st_q[`ASC_IRQ_SUS_BIT] <= 1'b1;  // RQ5
        end
      end
    end
  end

  // end pulse registered from done
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_end_irq_o <= 1'b0;
    end else begin
      conv_end_irq_o <= done;  // RQ14
    end
  end
  assign irq_o = |(irq_st_q & irq_msk_q);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [7:0] samp_run_q;  // cycles spent sampling
  logic [7:0] samp_len_q;  // expected sampling length
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      samp_run_q <= 8'h00;
      samp_len_q <= 8'h00;
    end else if (sample_o) begin
      samp_run_q <= samp_run_q + 8'h01;
    end else begin
      samp_run_q <= 8'h00;
      samp_len_q <= asc_samp_cycles(spd, mode_q[5:4]);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  flag_keep_a: assert property ( // RQ1
    wr_chsel & ~done |=> irq_st_q[0] == $past(irq_st_q[0]))
    else $error("channel write changed end flag");
  old_flag_a: assert property ( // RQ2
    done & wr_chsel |=> irq_st_q[0])
    else $error("old channel end lost on channel write");
  suspect_mark_a: assert property ( // RQ5
    en_rise & ~pwdata_i[1] & ~done |=> suspect_q)
    else $error("unpowered enable not marked suspect");
  result_undef_a: assert property ( // RQ7
    (wr_mode | wr_chsel) & ~done |=> ~result_vld_q)
    else $error("result still valid after mode write");
  samp_len_a: assert property ( // RQ10
    sample_o ##1 ~sample_o & en_bit |-> $past(samp_run_q) + 8'h01 == samp_len_q)
    else $error("sampling length differs from mode");
  start_delay_a: assert property ( // RQ11
    state_q == ST_IDLE & en_rise |=> ~sample_o [*5] ##1 (sample_o | ~en_bit))
    else $error("sampling not after start delay");
  wait_write_a: assert property ( // RQ12
    psel_i & penable_i & ~pready_o |=> $stable(mode_q) && $stable(chsel_q))
    else $error("write took effect before wait end");
  end_irq_a: assert property ( // RQ14
    done |=> conv_end_irq_o && irq_st_q[0] && result_q == $past(trial_q))
    else $error("conversion end not flagged");

  conv_done_c: cover property (done ##1 state_q == ST_SAMPLE);
  chsel_mid_c: cover property (state_q == ST_CONV && wr_chsel);
  suspect_c:   cover property (done && suspect_q);
  irq_clr_c:   cover property (irq_o ##[1:20] ~irq_o);
endmodule // asc_ctrl

//--- sim/asc_ctrl_tb.sv
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_ctrl_tb
  import asc_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic        sys_clk_i      = 1'b0;   // 40 MHz clock
  logic        reset_i        = 1'b1;   // held for 16 cycles
  logic        psel_i         = 1'b0;   // apb select
  logic        penable_i      = 1'b0;   // apb enable
  logic        pwrite_i       = 1'b0;   // apb direction
  logic [7:0]  paddr_i        = 8'h00;  // apb address
  logic [31:0] pwdata_i       = 32'h0;  // apb write data
  logic        comp_i         = 1'b0;   // comparator model output
  logic [31:0] prdata_o;                // apb read data
  logic        pready_o;                // apb ready
  logic        pslverr_o;               // apb error
  logic        sample_o;                // sample gate
  logic [2:0]  channel_o;               // mux select
  logic [9:0]  dac_code_o;              // trial code
  logic        power_on_o;              // converter power
  logic        conv_end_irq_o;          // end pulse
  logic        irq_o;                   // level interrupt
  asc_code_t   vin            = 10'h000; // analog input as a code
  logic [31:0] rd;                      // last read data
  logic        err;                     // last error response
  int          miscompares    = 0;      // mismatch count
  int          n_compared     = 0;      // comparison count
  int          seed           = 32'hC9A0; // fixed seed
  // ---------------------------------------------------------------
  // clock and comparator
  // ---------------------------------------------------------------
  always #12.5 sys_clk_i = ~sys_clk_i;
  // comparator says 1 while the input is at or above the trial code
  always @(posedge sys_clk_i) begin
    comp_i <= (dac_code_o <= vin);
  end
  asc_ctrl dut (
    .sys_clk_i     (sys_clk_i),
    .reset_i       (reset_i),
    .psel_i        (psel_i),
    .penable_i     (penable_i),
    .pwrite_i      (pwrite_i),
    .paddr_i       (paddr_i),
    .pwdata_i      (pwdata_i),
    .prdata_o      (prdata_o),
    .pready_o      (pready_o),
    .pslverr_o     (pslverr_o),
    .comp_i        (comp_i),
    .sample_o      (sample_o),
    .channel_o     (channel_o),
    .dac_code_o    (dac_code_o),
    .power_on_o    (power_on_o),
    .conv_end_irq_o(conv_end_irq_o),
    .irq_o         (irq_o)
  );
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  // ends the run with the verdict
  task give_verdict();
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // compares one value and reports a mismatch
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // ready, read data and error are taken at a rising edge only
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      give_verdict();
    end
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // reads a register and compares it
  task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask
  // one conversion from enable to stop, then flag and interrupt handling
  task run(input logic [1:0] sp, input logic [1:0] sel, input logic pwr, input logic susp);
    int n;
    int samp;
    logic [2:0] ch;
    apb(1'b1, `ASC_MODE_OFF, {26'h0, sel, sp, pwr, 1'b1});
    n = 0;
    while (sample_o !== 1'b1 && n < 20) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("start_delay", (n >= 4 && n <= 7), 32'h1);
    samp = 0;
    while (sample_o === 1'b1 && samp < 200) begin
      @(negedge sys_clk_i);
      samp++;
    end
    chk("sample_len", samp, (sp == 2'b00 ? 32 : 8) * (sel + 1));
    n = 0;
    while (conv_end_irq_o !== 1'b1 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("end_pulse", conv_end_irq_o, 32'h1);
    @(negedge sys_clk_i);
    chk("end_pulse_len", conv_end_irq_o, 32'h0);
    // results are read before any mode or channel write
    rchk("result", `ASC_RESULT_OFF, {22'h0, vin});
    rchk("result_high", `ASC_RESULT_H_OFF, {24'h0, vin[9:2]});
    rchk("chan_result", `ASC_CHRES_OFF, {22'h0, vin});
    apb(1'b0, `ASC_STATUS_OFF, 32'h0);
    chk("valid_set", rd[0], 32'h1);
    rchk("irq_status", `ASC_IRQ_ST_OFF, {30'h0, susp, 1'b1});
    // normal speed: stop only while sampling, never during the steps
    while (sp == 2'b00 && sample_o !== 1'b1) @(posedge sys_clk_i);
    apb(1'b1, `ASC_MODE_OFF, {26'h0, sel, sp, pwr, 1'b0});
    apb(1'b0, `ASC_STATUS_OFF, 32'h0);
    chk("valid_after_mode", rd[0], 32'h0);
    ch = 3'($random(seed));
    apb(1'b1, `ASC_CHSEL_OFF, {29'h0, ch});
    @(negedge sys_clk_i);
    chk("channel_o", channel_o, ch);
    rchk("flag_kept", `ASC_IRQ_ST_OFF, {30'h0, susp, 1'b1});
    chk("irq_masked", irq_o, 32'h0);
    apb(1'b1, `ASC_IRQ_MSK_OFF, 32'h1);
    @(negedge sys_clk_i);
    chk("irq_unmasked", irq_o, 32'h1);
    // flag cleared before the next start
    apb(1'b1, `ASC_IRQ_ST_OFF, 32'h3);
    @(negedge sys_clk_i);
    chk("irq_cleared", irq_o, 32'h0);
    rchk("status_cleared", `ASC_IRQ_ST_OFF, 32'h0);
    apb(1'b1, `ASC_IRQ_MSK_OFF, 32'h0);
  endtask
  // ---------------------------------------------------------------
  // watchdog, 20000 cycles is far beyond the expected run
  // ---------------------------------------------------------------
  initial begin
    #500000;
    miscompares++;
    give_verdict();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("rst_outputs", {channel_o, power_on_o, irq_o, sample_o, conv_end_irq_o}, 32'h0);
    rchk("rst_mode", `ASC_MODE_OFF, 32'h0);
    rchk("rst_chsel", `ASC_CHSEL_OFF, 32'h0);
    rchk("rst_irq_st", `ASC_IRQ_ST_OFF, 32'h0);
    rchk("rst_mask", `ASC_IRQ_MSK_OFF, 32'h0);
    apb(1'b0, `ASC_STATUS_OFF, 32'h0);
    chk("rst_state", rd[11:7], 32'h1);
    // unmapped, misaligned and read-only accesses
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_rd", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    chk("unmapped_wr", err, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    chk("misaligned", err, 32'h1);
    apb(1'b1, `ASC_RESULT_OFF, 32'h3FF);
    rchk("result_ro", `ASC_RESULT_OFF, 32'h0);
    // enable with power off gives a suspect first result
    vin = 10'h3FF;
    run(2'b01, 2'd0, 1'b0, 1'b1);
    // power on then enable at once, before settling
    apb(1'b1, `ASC_MODE_OFF, 32'h6);
    @(negedge sys_clk_i);
    chk("power_on", power_on_o, 32'h1);
    apb(1'b0, `ASC_STATUS_OFF, 32'h0);
    chk("not_settled", rd[2], 32'h0);
    vin = 10'h000;
    run(2'b01, 2'd3, 1'b1, 1'b1);
    // wait past the longest settle time, then clean results
    repeat (600) @(posedge sys_clk_i);
    apb(1'b0, `ASC_STATUS_OFF, 32'h0);
    chk("settled", rd[2], 32'h1);
    for (int i = 0; i < 4; i++) begin
      vin = (i == 0) ? 10'h200 : 10'($random(seed));
      run(2'(i % 3), 2'(i), 1'b1, 1'b0);
    end
    give_verdict();
  end
endmodule // asc_ctrl_tb
